// ---- dtc_io_cond.sv ----
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// - Inputs active when shorted; polarity bit inverts
// - Five base inputs, five extension; two words
// - Each input maps to one of fifty functions
// - Pulse counting only from the fifth input
// - Filter rejects changes shorter than filter time
// - Own delay on each of first three inputs
// - Each output follows one of forty functions
// - Mode 0 pulse output, mode 1 switched
// - Pulse frequency proportional, 100 percent 100 kHz
// - Analog output equals scale times value plus offset
module dtc_io_cond
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Terminal pins
   input wire logic [9:0] switch_input,
   output logic pulse_freq_output,
   output logic [3:0] digital_out,
   // Drive side
   input wire logic [39:0] drive_status,
   input wire logic [3:0][15:0] pulse_param,
   input wire logic [1:0][15:0] aout_raw,
   output logic [49:0] func_active,
   output logic [1:0][15:0] analog_out_channel
);
   typedef struct packed {
      logic [9:0] sync1;
      logic [9:0] sync2;
      logic [9:0] pol_lvl;
      logic [9:0] filt;
      logic [9:0][15:0] fcnt;
      logic [2:0] dly;
      logic [2:0][15:0] dcnt;
      logic [9:0] lvl;
      logic [7:0] tick_cnt;
      logic tick;
      logic [31:0] pcount;
      logic mode;
      logic ext_en;
      logic [4:0] pol_lo;
      logic [4:0] pol_hi;
      logic [15:0] filt_time;
      logic [2:0][15:0] dly_time;
      logic [9:0][5:0] in_sel;
      logic [4:0][5:0] out_sel;
      logic [1:0] src_sel;
      logic [1:0][15:0] scale;
      logic [1:0][15:0] offs;
      logic aw_full;
      logic w_full;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [49:0] func;
      logic [3:0] dout;
      logic pin;
      logic [1:0][15:0] aout;
   } dtc_state_t;

   dtc_state_t st;
   dtc_state_t n;
   logic pulse_raw;

   ////////////////////////////////////////////////////////////////////////
   // Hold a level change until it has lasted lim ticks
   function automatic logic [16:0] settle(input logic cur, input logic tgt,
      input logic [15:0] cnt, input logic [15:0] lim, input logic tick);
      logic [16:0] r;
      r = {cur, 16'h0000};
      if (tgt != cur)
      begin
         if (cnt >= lim)
            r = {tgt, 16'h0000};
         else if (tick)
            r = {cur, 16'(cnt + 16'h0001)};
         else
            r = {cur, cnt};
      end
      return r;
   endfunction

   function automatic logic stat_pick(input logic [39:0] s,
      input logic [5:0] sel);
      logic r;
      r = 1'b0;
      if (sel < 6'(dtc_pkg::N_OUT_FUNC))
         r = s[sel];
      return r;
   endfunction

   function automatic logic [15:0] correct(input logic [15:0] x,
      input logic [15:0] k, input logic [15:0] b);
      logic signed [16:0] xs;
      logic signed [32:0] p;
      logic signed [33:0] y;
      logic [15:0] r;
      xs = signed'({1'b0, x});
      p = xs * signed'(k);
      y = 34'(p >>> dtc_pkg::SCALE_FRAC) + 34'(signed'(b));
      if (y < 34'sh0_0000_0000)
         r = 16'h0000;
      else if (y > 34'sh0_0000_FFFF)
         r = 16'hFFFF;
      else
         r = y[15:0];
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (be[b])
            r[8*b +: 8] = d[8*b +: 8];
      return r;
   endfunction

   // Returns hit bit above the register word
   function automatic logic [32:0] rd_word(input dtc_state_t s,
      input logic [7:0] a);
      logic [32:0] r;
      r = {1'b1, 32'h0000_0000};
      case ({a[7:2], 2'b00})
         dtc_pkg::OFF_CTRL: r[1:0] = {s.ext_en, s.mode};
         dtc_pkg::OFF_POL_LO: r[4:0] = s.pol_lo;
         dtc_pkg::OFF_POL_HI: r[4:0] = s.pol_hi;
         dtc_pkg::OFF_FILT: r[15:0] = s.filt_time;
         dtc_pkg::OFF_DLY1: r[15:0] = s.dly_time[0];
         dtc_pkg::OFF_DLY2: r[15:0] = s.dly_time[1];
         dtc_pkg::OFF_DLY3: r[15:0] = s.dly_time[2];
         dtc_pkg::OFF_INSEL_LO: r[29:0] = s.in_sel[4:0];
         dtc_pkg::OFF_INSEL_HI: r[29:0] = s.in_sel[9:5];
         dtc_pkg::OFF_OUTSEL: r[29:0] = s.out_sel;
         dtc_pkg::OFF_SRC: r[1:0] = s.src_sel;
         dtc_pkg::OFF_SCALE0: r[15:0] = s.scale[0];
         dtc_pkg::OFF_OFFS0: r[15:0] = s.offs[0];
         dtc_pkg::OFF_SCALE1: r[15:0] = s.scale[1];
         dtc_pkg::OFF_OFFS1: r[15:0] = s.offs[1];
         dtc_pkg::OFF_LEVELS: r[9:0] = s.lvl;
         dtc_pkg::OFF_PCOUNT: r[31:0] = s.pcount;
         default: r = '0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   dtc_pulse_gen u_pulse
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(st.mode == dtc_pkg::MODE_PULSE),
      .percent(pulse_param[st.src_sel]),
      .pulse_out(pulse_raw)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [16:0] stp;
      logic [32:0] rw;
      logic [31:0] w;
      stp = '0;
      rw = '0;
      w = '0;
      n = st;
      // Input conditioning
      n.sync1 = switch_input;
      n.sync2 = st.sync1;
      n.pol_lvl = ~st.sync2 ^ {st.pol_hi, st.pol_lo};
      n.tick = (st.tick_cnt == 8'(dtc_pkg::TICK_CYC - 1));
      n.tick_cnt = n.tick ? 8'h00 : 8'(st.tick_cnt + 8'h01);
      for (int i = 0; i < dtc_pkg::N_IN; i++)
      begin
         stp = settle(st.filt[i], st.pol_lvl[i], st.fcnt[i], st.filt_time,
            st.tick);
         n.filt[i] = stp[16];
         n.fcnt[i] = stp[15:0];
      end
      for (int i = 0; i < dtc_pkg::N_DLY; i++)
      begin
         stp = settle(st.dly[i], st.filt[i], st.dcnt[i], st.dly_time[i],
            st.tick);
         n.dly[i] = stp[16];
         n.dcnt[i] = stp[15:0];
      end
      n.lvl = {st.filt[9:3], st.dly};
      if (!st.ext_en)
         n.lvl[9:5] = 5'h00;
      // Function mapping
      n.func = '0;
      for (int i = 0; i < dtc_pkg::N_IN; i++)
         if (st.lvl[i] && st.in_sel[i] != dtc_pkg::FUNC_NONE
            && st.in_sel[i] < 6'(dtc_pkg::N_IN_FUNC)
            && (st.in_sel[i] != dtc_pkg::PULSE_COUNT_FUNC
            || i == dtc_pkg::FAST_IDX))
            n.func[st.in_sel[i]] = 1'b1;
      if (st.in_sel[dtc_pkg::FAST_IDX] == dtc_pkg::PULSE_COUNT_FUNC
         && n.pol_lvl[dtc_pkg::FAST_IDX] && !st.pol_lvl[dtc_pkg::FAST_IDX])
         n.pcount = st.pcount + 32'h0000_0001;
      // Outputs
      for (int j = 0; j < dtc_pkg::N_OUT - 1; j++)
         n.dout[j] = stat_pick(drive_status, st.out_sel[j + 1]);
      if (st.mode == dtc_pkg::MODE_SWITCH)
         n.pin = stat_pick(drive_status, st.out_sel[0]);
      else
         n.pin = pulse_raw;
      for (int c = 0; c < 2; c++)
         n.aout[c] = correct(aout_raw[c], st.scale[c], st.offs[c]);
      // Bus write
      if (s_axi_awvalid && st.awready)
      begin
         n.aw_full = 1'b1;
         n.awaddr = 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && st.wready)
      begin
         n.w_full = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready)
         n.bvalid = 1'b0;
      if (n.aw_full && n.w_full && !n.bvalid)
      begin
         rw = rd_word(st, n.awaddr);
         w = merge(rw[31:0], n.wdata, n.wstrb);
         n.aw_full = 1'b0;
         n.w_full = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = rw[32] ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
         case ({n.awaddr[7:2], 2'b00})
            dtc_pkg::OFF_CTRL:
            begin
               n.mode = w[0];
               n.ext_en = w[1];
            end
            dtc_pkg::OFF_POL_LO: n.pol_lo = w[4:0];
            dtc_pkg::OFF_POL_HI: n.pol_hi = w[4:0];
            dtc_pkg::OFF_FILT: n.filt_time = w[15:0];
            dtc_pkg::OFF_DLY1: n.dly_time[0] = w[15:0];
            dtc_pkg::OFF_DLY2: n.dly_time[1] = w[15:0];
            dtc_pkg::OFF_DLY3: n.dly_time[2] = w[15:0];
            dtc_pkg::OFF_INSEL_LO: n.in_sel[4:0] = w[29:0];
            dtc_pkg::OFF_INSEL_HI: n.in_sel[9:5] = w[29:0];
            dtc_pkg::OFF_OUTSEL: n.out_sel = w[29:0];
            dtc_pkg::OFF_SRC: n.src_sel = w[1:0];
            dtc_pkg::OFF_SCALE0: n.scale[0] = w[15:0];
            dtc_pkg::OFF_OFFS0: n.offs[0] = w[15:0];
            dtc_pkg::OFF_SCALE1: n.scale[1] = w[15:0];
            dtc_pkg::OFF_OFFS1: n.offs[1] = w[15:0];
            default: n.bvalid = 1'b1;
         endcase
      end
      n.awready = !n.aw_full && !n.bvalid;
      n.wready = !n.w_full && !n.bvalid;
      // Bus read
      if (st.rvalid && s_axi_rready)
         n.rvalid = 1'b0;
      if (s_axi_arvalid && st.arready)
      begin
         rw = rd_word(st, 8'(s_axi_araddr));
         n.rvalid = 1'b1;
         n.rdata = rw[31:0];
         n.rresp = rw[32] ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
      end
      n.arready = !n.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
         st.sync1 <= '1;
         st.sync2 <= '1;
         st.pol_lo <= dtc_pkg::RST_POLARITY;
         st.pol_hi <= dtc_pkg::RST_POLARITY;
         st.scale <= {2{dtc_pkg::RST_SCALE}};
         st.offs <= {2{dtc_pkg::RST_OFFSET}};
      end
      else
         st <= n;
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign pulse_freq_output = st.pin;
   assign digital_out = st.dout;
   assign func_active = st.func;
   assign analog_out_channel = st.aout;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   pol_sense_a: assert property ($past(aresetn) |-> st.pol_lvl
      == (~$past(st.sync2) ^ $past({st.pol_hi, st.pol_lo})))
      else $error("input sense does not follow polarity");
   ext_gate_a: assert property (!$past(st.ext_en) |-> st.lvl[9:5] == 5'h00)
      else $error("extension inputs active while absent");
   func_map_a: assert property (st.lvl[0] && st.in_sel[0] == 6'd5
      |=> st.func[5])
      else $error("mapped function not raised");
   pulse_only_a: assert property ($changed(st.pcount)
      |-> $past(st.in_sel[4]) == 6'h1E && $rose(st.pol_lvl[4]))
      else $error("pulse count from wrong source");
   filter_hold_a: assert property ($changed(st.filt[0])
      |-> $past(st.fcnt[0]) >= $past(st.filt_time))
      else $error("filter passed a short change");
   delay_hold_a: assert property ($changed(st.dly[1])
      |-> $past(st.dcnt[1]) >= $past(st.dly_time[1]))
      else $error("delay ended early");
   out_map_a: assert property (st.out_sel[2] == 6'd39 && drive_status[39]
      |=> digital_out[1])
      else $error("output does not follow its function");
   pin_mode_a: assert property (st.mode == 1'b1 && st.out_sel[0] < 6'd40
      |=> pulse_freq_output == $past(drive_status[st.out_sel[0]]))
      else $error("switched pin does not follow status");
   aout_unity_a: assert property (st.scale[0] == 16'h1000
      && st.offs[0] == 16'h0000 |=> st.aout[0] == $past(aout_raw[0]))
      else $error("unity correction changed the value");
   bus_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
endmodule

// ---- dtc_pkg.sv ----
package dtc_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 5;
   localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Terminal counts
   localparam int N_IN = 10;
   localparam int N_BASE = 5;
   localparam int N_IN_FUNC = 50;
   localparam int N_OUT_FUNC = 40;
   localparam int N_OUT = 5;
   localparam int N_DLY = 3;
   localparam int N_SRC = 4;
   localparam int FAST_IDX = 4;
   localparam logic [5:0] FUNC_NONE = 6'h00;
   localparam logic [5:0] PULSE_COUNT_FUNC = 6'h1E;
   // Pulse output
   localparam int PULSE_MAX_HZ = 100_000;
   localparam int PULSE_MIN_HZ = 10;
   localparam int FULL_SCALE = 10_000;
   localparam int HZ_PER_UNIT = PULSE_MAX_HZ / FULL_SCALE;
   localparam logic MODE_PULSE = 1'b0;
   localparam logic MODE_SWITCH = 1'b1;
   // Analog correction
   localparam int SCALE_FRAC = 12;
   localparam logic [15:0] RST_SCALE = 16'h1000;
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   localparam logic [4:0] RST_POLARITY = 5'h00;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_POL_LO = 8'h04;
   localparam logic [7:0] OFF_POL_HI = 8'h08;
   localparam logic [7:0] OFF_FILT = 8'h0C;
   localparam logic [7:0] OFF_DLY1 = 8'h10;
   localparam logic [7:0] OFF_DLY2 = 8'h14;
   localparam logic [7:0] OFF_DLY3 = 8'h18;
   localparam logic [7:0] OFF_INSEL_LO = 8'h1C;
   localparam logic [7:0] OFF_INSEL_HI = 8'h20;
   localparam logic [7:0] OFF_OUTSEL = 8'h24;
   localparam logic [7:0] OFF_SRC = 8'h28;
   localparam logic [7:0] OFF_SCALE0 = 8'h2C;
   localparam logic [7:0] OFF_OFFS0 = 8'h30;
   localparam logic [7:0] OFF_SCALE1 = 8'h34;
   localparam logic [7:0] OFF_OFFS1 = 8'h38;
   localparam logic [7:0] OFF_LEVELS = 8'h3C;
   localparam logic [7:0] OFF_PCOUNT = 8'h40;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- dtc_pulse_gen.sv ----
`timescale 1ns/1ps
module dtc_pulse_gen
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic enable,
   input wire logic [15:0] percent,
   // Pin
   output logic pulse_out
);
   typedef struct packed {
      logic [27:0] acc;
      logic [16:0] freq;
      logic out;
   } dtc_pg_state_t;

   dtc_pg_state_t st;
   dtc_pg_state_t n;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [31:0] f;
      logic [28:0] sum;
      f = '0;
      sum = '0;
      n = st;
      f = 32'(percent) * 32'(dtc_pkg::HZ_PER_UNIT);
      if (f < 32'(dtc_pkg::PULSE_MIN_HZ))
         n.freq = 17'(dtc_pkg::PULSE_MIN_HZ);
      else if (f > 32'(dtc_pkg::PULSE_MAX_HZ))
         n.freq = 17'(dtc_pkg::PULSE_MAX_HZ);
      else
         n.freq = f[16:0];
      // Two edges per period
      sum = 29'(st.acc) + 29'({st.freq, 1'b0});
      if (sum >= 29'(dtc_pkg::CLK_HZ))
      begin
         n.acc = 28'(sum - 29'(dtc_pkg::CLK_HZ));
         n.out = ~st.out;
      end
      else
         n.acc = sum[27:0];
      if (!enable)
      begin
         n.acc = '0;
         n.out = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
         st.freq <= 17'(dtc_pkg::PULSE_MIN_HZ);
      end
      else
         st <= n;
   end

   assign pulse_out = st.out;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   freq_range_a: assert property (st.freq >= 17'd10 && st.freq <= 17'd100000)
      else $error("pulse frequency out of range");
   full_scale_a: assert property ($stable(percent) && percent == 16'd10000
      |=> st.freq == 17'd100000)
      else $error("full scale does not give top frequency");
   toggle_cause_a: assert property ($past(enable) && enable && $changed(st.out)
      |-> 29'($past(st.acc)) + 29'({$past(st.freq), 1'b0}) >= 29'd200000000)
      else $error("pulse edge without accumulator wrap");
endmodule

// ---- dtc_field_model.sv ----
`timescale 1ns/1ps
module dtc_field_model
(
   // Contacts set by the bench
   input wire logic [9:0] closed,
   input wire logic ext_fitted,
   // Terminal lines
   output logic [9:0] switch_input
);
   ////////////////////////////////////////////////////////////////////////
   // Closed contact pulls its line to common, open line sits at pull-up
   always_comb
   begin
      switch_input[4:0] = ~closed[4:0];
      // Without the extension card the upper lines just float high
      switch_input[9:5] = ext_fitted ? ~closed[9:5] : 5'h1F;
   end
endmodule

// ---- drive_terminal_io_conditioning_test.sv ----
`timescale 1ns/1ps
module drive_terminal_io_conditioning_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [9:0] closed = 10'h000, switch_input;
   logic ext_fitted = 1'b1;
   logic pulse_freq_output;
   logic [3:0] digital_out;
   logic [39:0] drive_status = 40'h00_0000_0000;
   logic [3:0][15:0] pulse_param = '0;
   logic [1:0][15:0] aout_raw = '0;
   logic [49:0] func_active;
   logic [1:0][15:0] analog_out_channel;
   int errors = 0, compares = 0, cycles = 0;

   always #2.5 aclk = ~aclk;

   dtc_io_cond u_dtc_io_cond (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .switch_input(switch_input), .pulse_freq_output(pulse_freq_output),
      .digital_out(digital_out), .drive_status(drive_status),
      .pulse_param(pulse_param), .aout_raw(aout_raw),
      .func_active(func_active), .analog_out_channel(analog_out_channel));

   dtc_field_model u_dtc_field_model (.closed(closed),
      .ext_fitted(ext_fitted), .switch_input(switch_input));

   ////////////////////////////////////////////////////////////////////////
   task report_and_stop();
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         errors++;
         report_and_stop();
      end
   end

   task check(input string what, input logic [31:0] exp,
              input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Bus cycles
   task axi_wr(input logic [7:0] a, input logic [31:0] d,
               input logic [1:0] exp);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check("bresp", {30'h0, exp}, {30'h0, bresp});
   endtask

   task axi_rd(input logic [7:0] a, input logic [31:0] exp,
               input logic [1:0] rexp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      check("rdata", exp, rdata);
      check("rresp", {30'h0, rexp}, {30'h0, rresp});
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, dtc_pkg::RESP_OKAY);
   endtask

   task wait_fa(input int k, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && func_active[k] !== v; i++)
         @(posedge aclk);
      check("func_active", {31'h0, v}, {31'h0, func_active[k]});
   endtask

   task count_edges(input int cyc, output int n);
      logic prev;
      n = 0;
      prev = pulse_freq_output;
      repeat (cyc)
      begin
         @(posedge aclk);
         if (pulse_freq_output === 1'b1 && prev === 1'b0)
            n++;
         prev = pulse_freq_output;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_reset_regs();
      axi_rd(dtc_pkg::OFF_CTRL, 32'h0000_0000, 2'h0);
      axi_rd(dtc_pkg::OFF_POL_LO, 32'h0000_0000, 2'h0);
      axi_rd(dtc_pkg::OFF_POL_HI, 32'h0000_0000, 2'h0);
      axi_rd(dtc_pkg::OFF_SCALE0, 32'h0000_1000, 2'h0);
      axi_rd(8'h44, 32'h0000_0000, dtc_pkg::RESP_SLVERR);
      axi_wr(8'h44, 32'h0000_0001, dtc_pkg::RESP_SLVERR);
      closed <= 10'h3E0;
      wr(dtc_pkg::OFF_LEVELS, 32'h0000_03FF);
      repeat (10) @(posedge aclk);
      axi_rd(dtc_pkg::OFF_LEVELS, 32'h0000_0000, 2'h0);
      closed <= 10'h000;
      repeat (10) @(posedge aclk);
   endtask

   task t_polarity();
      wr(dtc_pkg::OFF_CTRL, 32'h0000_0002);
      wr(dtc_pkg::OFF_INSEL_LO, 32'h0000_0005);
      wr(dtc_pkg::OFF_INSEL_HI, 32'h0000_0240);
      closed <= 10'h001;
      wait_fa(5, 1'b1, 20);
      axi_rd(dtc_pkg::OFF_LEVELS, 32'h0000_0001, 2'h0);
      check("func idle", 32'h0, {31'h0, func_active[9]});
      wr(dtc_pkg::OFF_POL_HI, 32'h0000_0002);
      wait_fa(9, 1'b1, 20);
      wr(dtc_pkg::OFF_POL_LO, 32'h0000_0001);
      wait_fa(5, 1'b0, 20);
      axi_rd(dtc_pkg::OFF_POL_HI, 32'h0000_0002, 2'h0);
      closed <= 10'h000;
      wr(dtc_pkg::OFF_POL_LO, 32'h0000_0000);
      wr(dtc_pkg::OFF_POL_HI, 32'h0000_0000);
   endtask

   task t_delay();
      wr(dtc_pkg::OFF_DLY1, 32'h0000_0003);
      wr(dtc_pkg::OFF_INSEL_LO, 32'h0000_0081);
      closed <= 10'h003;
      wait_fa(2, 1'b1, 20);
      repeat (330) @(posedge aclk);
      check("delayed early", 32'h0, {31'h0, func_active[1]});
      wait_fa(1, 1'b1, 900);
      closed <= 10'h000;
      wr(dtc_pkg::OFF_DLY1, 32'h0000_0000);
      wait_fa(1, 1'b0, 900);
   endtask

   task t_filter();
      wr(dtc_pkg::OFF_FILT, 32'h0000_0002);
      wr(dtc_pkg::OFF_INSEL_LO, 32'h0000_4000);
      closed <= 10'h004;
      repeat (100) @(posedge aclk);
      closed <= 10'h000;
      repeat (500) @(posedge aclk);
      check("glitch passed", 32'h0, {31'h0, func_active[4]});
      closed <= 10'h004;
      wait_fa(4, 1'b1, 700);
      closed <= 10'h000;
      wr(dtc_pkg::OFF_FILT, 32'h0000_0000);
      wait_fa(4, 1'b0, 700);
   endtask

   task t_count();
      wr(dtc_pkg::OFF_INSEL_LO, 32'h1E00_001E);
      repeat (3)
      begin
         closed <= 10'h001;
         repeat (10) @(posedge aclk);
         closed <= 10'h000;
         repeat (10) @(posedge aclk);
      end
      axi_rd(dtc_pkg::OFF_PCOUNT, 32'h0000_0000, 2'h0);
      repeat (3)
      begin
         closed <= 10'h010;
         repeat (10) @(posedge aclk);
         closed <= 10'h000;
         repeat (10) @(posedge aclk);
      end
      axi_rd(dtc_pkg::OFF_PCOUNT, 32'h0000_0003, 2'h0);
      wr(dtc_pkg::OFF_INSEL_LO, 32'h0000_0000);
   endtask

   task t_outputs();
      wr(dtc_pkg::OFF_CTRL, 32'h0000_0003);
      wr(dtc_pkg::OFF_OUTSEL, 32'h00A2_71C3);
      drive_status <= 40'hFF_FFFF_FFFF;
      repeat (4) @(posedge aclk);
      check("pin", 32'h1, {31'h0, pulse_freq_output});
      check("digital_out", 32'hB, {28'h0, digital_out});
      drive_status <= 40'h00_0000_0008;
      repeat (4) @(posedge aclk);
      check("pin", 32'h1, {31'h0, pulse_freq_output});
      check("digital_out", 32'h0, {28'h0, digital_out});
      drive_status <= 40'h00_0000_0000;
      repeat (4) @(posedge aclk);
      check("pin", 32'h0, {31'h0, pulse_freq_output});
   endtask

   task t_pulse();
      int n;
      pulse_param <= {16'h0000, 16'd10000, 16'd5000, 16'h0000};
      wr(dtc_pkg::OFF_CTRL, 32'h0000_0002);
      wr(dtc_pkg::OFF_SRC, 32'h0000_0002);
      repeat (2000) @(posedge aclk);
      count_edges(20000, n);
      check("edges full", 32'h1, {31'h0, n >= 9 && n <= 11});
      wr(dtc_pkg::OFF_SRC, 32'h0000_0001);
      repeat (2000) @(posedge aclk);
      count_edges(20000, n);
      check("edges half", 32'h1, {31'h0, n >= 4 && n <= 6});
   endtask

   task t_analog();
      wr(dtc_pkg::OFF_SCALE0, 32'h0000_2000);
      wr(dtc_pkg::OFF_OFFS0, 32'h0000_0010);
      wr(dtc_pkg::OFF_SCALE1, 32'h0000_F000);
      wr(dtc_pkg::OFF_OFFS1, 32'h0000_03E8);
      aout_raw <= {16'd100, 16'd100};
      repeat (3) @(posedge aclk);
      check("aout0", 32'd216, {16'h0, analog_out_channel[0]});
      check("aout1", 32'd900, {16'h0, analog_out_channel[1]});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_regs();
      t_polarity();
      t_delay();
      t_filter();
      t_count();
      t_outputs();
      t_pulse();
      t_analog();
      report_and_stop();
   end
endmodule
